// [core/gxp_pkg.sv]
package gxp_pkg;

  // register offsets
  localparam logic [7:0] ADR_INVERT   = 8'h06;
  localparam logic [7:0] ADR_DIR      = 8'h07;
  localparam logic [7:0] ADR_DATA     = 8'h08;
  localparam logic [7:0] ADR_MASK     = 8'h09;
  localparam logic [7:0] ADR_SENSE_HI = 8'h0a;
  localparam logic [7:0] ADR_SENSE_LO = 8'h0b;
  localparam logic [7:0] ADR_SRC      = 8'h0c;
  localparam logic [7:0] ADR_EVT      = 8'h0d;
  localparam logic [7:0] ADR_LSHIFT   = 8'h0e;
  localparam logic [7:0] ADR_CLK      = 8'h0f;
  localparam logic [7:0] ADR_MISC     = 8'h10;

  // reset values
  localparam logic [7:0] RST_DIR  = 8'hff;
  localparam logic [7:0] RST_DATA = 8'hff;
  localparam logic [7:0] RST_MASK = 8'hff;

  // field positions
  localparam int CLK_SRC_LSB   = 5;
  localparam int CLK_PIN_DIR   = 4;
  localparam int MISC_FADE_B   = 7;
  localparam int MISC_NO_INC   = 1;
  localparam int MISC_NO_CLR   = 0;

  // field encodings
  localparam logic [1:0] SRC_OFF    = 2'h0;
  localparam logic [1:0] SRC_EXT    = 2'h1;
  localparam logic [1:0] SRC_INT    = 2'h2;
  localparam logic [1:0] LS_A2B     = 2'h1;
  localparam logic [1:0] LS_B2A     = 2'h2;
  localparam logic [3:0] CLKOUT_LOW = 4'h0;
  localparam logic [3:0] CLKOUT_HI  = 4'hf;
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  localparam logic [3:0] LAST_RBIT  = 4'h7;

  // internal oscillator, rounded down to whole cycles
  localparam int CLK_HZ          = 50_000_000;
  localparam int INT_OSC_HZ      = 2_000_000;
  localparam int OSC_HALF_CYCLES = CLK_HZ / (2 * INT_OSC_HZ);
  localparam logic [3:0] OSC_HALF_LAST = 4'(OSC_HALF_CYCLES - 1);

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_REG, I2C_ACK_REG,
    I2C_WDATA, I2C_ACK_W, I2C_RDATA, I2C_RACK
  } gxp_i2c_st_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } gxp_i2c_in_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gxp_io_type;

  typedef struct packed {
    gxp_i2c_st_type st;
    logic [3:0]     cnt;
    logic [7:0]     sh;
    logic [7:0]     ptr;
    logic           rw;
    logic           sda_oe;
    logic [7:0]     inv;
    logic [7:0]     dir;
    logic [7:0]     data;
    logic [7:0]     mask;
    logic [15:0]    sense;
    logic [7:0]     src;
    logic [7:0]     evt;
    logic [7:0]     lshift;
    logic [7:0]     clk_cfg;
    logic [7:0]     misc;
    logic [7:0]     io_s1;
    logic [7:0]     io_s2;
    logic [7:0]     io_prev;
    logic           scl_s1;
    logic           scl_s2;
    logic           scl_p;
    logic           sda_s1;
    logic           sda_s2;
    logic           sda_p;
    logic           osc_s1;
    logic           osc_s2;
    logic [3:0]     int_cnt;
    logic           int_ph;
    logic           osc_frequency_p;
    logic [12:0]    div;
    logic           clk_out;
  } gxp_state_type;

  localparam gxp_state_type STATE_RST = '{st: I2C_IDLE, dir: RST_DIR, data: RST_DATA,
                                          mask: RST_MASK, default: '0};

endpackage

// [core/gxp_core.sv]
// Operation
// - direction bit 0 output, 1 input; reset ff
// - written data drives output lines; reset ff
// - data read returns current level of lines
// - mask 0 lets event interrupt; reset masked
// - upper sense fields for lines 7..4
// - lower sense fields lines 3..0, reset zero
// - sense codes: none, rise, fall, both
// - unmasked configured edge sets source bit
// - write one clears source and event bits
// - interrupt low while any source bit set
// - configured edge sets event bit regardless mask
// - write one clears event and source bits
// - sense change clears that line's flags
// - translate fields pair line n with n+4
// - oscillator source: off, external, internal 2MHz
// - oscillator pin direction: 0 input, 1 output
// - clock out: low, high, or divided oscillator
// - misc bit 7 selects fade law (fade_law_log), not tied to a line
// - inversion bit inverts data versus pad level
// - auto-clear: data read clears source bits
`timescale 1ns/1ns
`default_nettype none

module gxp_core #(
  parameter logic [6:0] DEV_ADDR = 7'h3e
) (
  // system
  input  wire logic                   clk,
  input  wire logic                   srst,
  // serial register port
  input  wire gxp_pkg::gxp_i2c_in_type i2c_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  // io lines
  input  wire logic [7:0]             io_in,
  output gxp_pkg::gxp_io_type         io_pad,
  // interrupt, oscillator and fade law
  output logic                        irq_out_n,
  input  wire logic                   osc_shared_pin_in,
  output logic                        osc_shared_pin_out,
  output logic                        osc_shared_pin_oe,
  output logic                        engines_enable,
  output logic                        fade_law_log
);

  gxp_pkg::gxp_state_type q;
  gxp_pkg::gxp_state_type d;
  logic [7:0]             ev;
  logic [7:0]             lvl;
  logic [7:0]             chg;
  logic [7:0]             clr_src;
  logic [7:0]             clr_evt;
  logic [7:0]             rd_data;
  logic [7:0]             inc;
  logic                   wr_en;
  logic                   rd_en;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start;
  logic                   stop;
  logic                   osc_frequency;
  logic [1:0]             osc_src;
  logic [3:0]             out_sel;

  assign lvl      = q.io_s2 ^ q.inv;
  assign scl_rise = q.scl_s2 & ~q.scl_p;
  assign scl_fall = ~q.scl_s2 & q.scl_p;
  assign start    = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
  assign stop     = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
  assign inc      = {7'h00, ~q.misc[gxp_pkg::MISC_NO_INC]};
  assign osc_src  = q.clk_cfg[gxp_pkg::CLK_SRC_LSB +: 2];
  assign out_sel  = q.clk_cfg[3:0];

  // per-line edge detection and pad drive
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_line
      logic rise;
      logic fall;
      logic [1:0] ls;
      logic fwd;
      logic [7:0] src_line;
      assign rise = lvl[g] & ~(q.io_prev[g] ^ q.inv[g]);
      assign fall = ~lvl[g] & (q.io_prev[g] ^ q.inv[g]);
      assign ev[g] = (q.sense[2*g] & rise) | (q.sense[2*g+1] & fall);
      assign ls = q.lshift[2*(g%4) +: 2];
      assign fwd = (g < 4) ? (ls == gxp_pkg::LS_B2A) : (ls == gxp_pkg::LS_A2B);
      assign src_line = q.io_s2;
      assign io_pad.oe[g]  = fwd | ~q.dir[g];
      assign io_pad.out[g] = fwd ? src_line[(g + 4) % 8] : (q.data[g] ^ q.inv[g]);
    end
  endgenerate

  always_comb begin
    d = q;
    wr_en = 1'b0;
    rd_en = 1'b0;
    clr_src = 8'h00;
    clr_evt = 8'h00;
    chg = 8'h00;
    osc_frequency = 1'b0;
    case (q.ptr)
      gxp_pkg::ADR_INVERT:   rd_data = q.inv;
      gxp_pkg::ADR_DIR:      rd_data = q.dir;
      gxp_pkg::ADR_DATA:     rd_data = lvl;
      gxp_pkg::ADR_MASK:     rd_data = q.mask;
      gxp_pkg::ADR_SENSE_HI: rd_data = q.sense[15:8];
      gxp_pkg::ADR_SENSE_LO: rd_data = q.sense[7:0];
      gxp_pkg::ADR_SRC:      rd_data = q.src;
      gxp_pkg::ADR_EVT:      rd_data = q.evt;
      gxp_pkg::ADR_LSHIFT:   rd_data = q.lshift;
      gxp_pkg::ADR_CLK:      rd_data = q.clk_cfg;
      gxp_pkg::ADR_MISC:     rd_data = q.misc;
      default:               rd_data = 8'h00;
    endcase
    // synchronisers
    d.io_s1 = io_in;
    d.io_s2 = q.io_s1;
    d.io_prev = q.io_s2;
    d.scl_s1 = i2c_in.scl;
    d.scl_s2 = q.scl_s1;
    d.scl_p = q.scl_s2;
    d.sda_s1 = i2c_in.sda;
    d.sda_s2 = q.sda_s1;
    d.sda_p = q.sda_s2;
    d.osc_s1 = osc_shared_pin_in;
    d.osc_s2 = q.osc_s1;
    // serial slave
    if (start) begin
      d.st = gxp_pkg::I2C_ADDR;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.st = gxp_pkg::I2C_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (q.st)
        gxp_pkg::I2C_ADDR, gxp_pkg::I2C_REG, gxp_pkg::I2C_WDATA: begin
          d.sh = {q.sh[6:0], q.sda_s2};
          d.cnt = q.cnt + 4'h1;
        end
        gxp_pkg::I2C_RACK: begin
          if (q.sda_s2) begin
            d.st = gxp_pkg::I2C_IDLE;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (q.st)
        gxp_pkg::I2C_ADDR: begin
          if (q.cnt == gxp_pkg::BITS_BYTE) begin
            if (q.sh[7:1] == DEV_ADDR) begin
              d.st = gxp_pkg::I2C_ACK_ADDR;
              d.rw = q.sh[0];
              d.sda_oe = 1'b1;
            end else begin
              d.st = gxp_pkg::I2C_IDLE;
            end
          end
        end
        gxp_pkg::I2C_ACK_ADDR, gxp_pkg::I2C_RACK: begin
          d.cnt = 4'h0;
          if (q.rw) begin
            rd_en = 1'b1;
            d.sh = rd_data;
            d.sda_oe = ~rd_data[7];
            d.ptr = q.ptr + inc;
            d.st = gxp_pkg::I2C_RDATA;
          end else begin
            d.sda_oe = 1'b0;
            d.st = gxp_pkg::I2C_REG;
          end
        end
        gxp_pkg::I2C_REG: begin
          if (q.cnt == gxp_pkg::BITS_BYTE) begin
            d.ptr = q.sh;
            d.sda_oe = 1'b1;
            d.st = gxp_pkg::I2C_ACK_REG;
          end
        end
        gxp_pkg::I2C_WDATA: begin
          if (q.cnt == gxp_pkg::BITS_BYTE) begin
            wr_en = 1'b1;
            d.ptr = q.ptr + inc;
            d.sda_oe = 1'b1;
            d.st = gxp_pkg::I2C_ACK_W;
          end
        end
        gxp_pkg::I2C_ACK_REG, gxp_pkg::I2C_ACK_W: begin
          d.cnt = 4'h0;
          d.sda_oe = 1'b0;
          d.st = gxp_pkg::I2C_WDATA;
        end
        gxp_pkg::I2C_RDATA: begin
          if (q.cnt == gxp_pkg::LAST_RBIT) begin
            d.sda_oe = 1'b0;
            d.st = gxp_pkg::I2C_RACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
            d.cnt = q.cnt + 4'h1;
          end
        end
        default: ;
      endcase
    end
    // register writes
    if (wr_en) begin
      case (q.ptr)
        gxp_pkg::ADR_INVERT:   d.inv = q.sh;
        gxp_pkg::ADR_DIR:      d.dir = q.sh;
        gxp_pkg::ADR_DATA:     d.data = q.sh;
        gxp_pkg::ADR_MASK:     d.mask = q.sh;
        gxp_pkg::ADR_SENSE_HI: d.sense[15:8] = q.sh;
        gxp_pkg::ADR_SENSE_LO: d.sense[7:0] = q.sh;
        gxp_pkg::ADR_SRC, gxp_pkg::ADR_EVT: begin
          clr_src = q.sh;
          clr_evt = q.sh;
        end
        gxp_pkg::ADR_LSHIFT:   d.lshift = q.sh;
        gxp_pkg::ADR_CLK:      d.clk_cfg = q.sh;
        gxp_pkg::ADR_MISC:     d.misc = q.sh;
        default: ;
      endcase
    end
    for (int i = 0; i < 8; i++) begin
      chg[i] = d.sense[2*i +: 2] != q.sense[2*i +: 2];
    end
    if (rd_en && q.ptr == gxp_pkg::ADR_DATA && !q.misc[gxp_pkg::MISC_NO_CLR]) begin
      clr_src = 8'hff;
    end
    // new events win over clears in the same cycle
    d.evt = (q.evt & ~clr_evt & ~chg) | ev;
    d.src = (q.src & ~clr_src & ~chg) | (ev & ~q.mask);
    // oscillator and divided output
    if (q.int_cnt == gxp_pkg::OSC_HALF_LAST) begin
      d.int_cnt = 4'h0;
      d.int_ph = ~q.int_ph;
    end else begin
      d.int_cnt = q.int_cnt + 4'h1;
    end
    case (osc_src)
      gxp_pkg::SRC_INT: osc_frequency = q.int_ph;
      gxp_pkg::SRC_EXT: osc_frequency = q.osc_s2 & ~q.clk_cfg[gxp_pkg::CLK_PIN_DIR];
      default:          osc_frequency = 1'b0;
    endcase
    d.osc_frequency_p = osc_frequency;
    if (osc_frequency && !q.osc_frequency_p) begin
      d.div = q.div + 13'h0001;
    end
    case (out_sel)
      gxp_pkg::CLKOUT_LOW: d.clk_out = 1'b0;
      gxp_pkg::CLKOUT_HI:  d.clk_out = 1'b1;
      4'h1:                d.clk_out = osc_frequency;
      default:             d.clk_out = q.div[out_sel - 4'h2];
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= gxp_pkg::STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign sda_out            = 1'b0;
  assign sda_oe             = q.sda_oe;
  assign irq_out_n          = ~|q.src;
  assign osc_shared_pin_oe  = q.clk_cfg[gxp_pkg::CLK_PIN_DIR];
  assign osc_shared_pin_out = q.clk_out;
  assign engines_enable     = (osc_src == gxp_pkg::SRC_EXT) | (osc_src == gxp_pkg::SRC_INT);
  assign fade_law_log       = q.misc[gxp_pkg::MISC_FADE_B];

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  dir_drive_a: assert property (q.lshift == 8'h00 |-> io_pad.oe == ~q.dir)
    else $error("output enable does not follow direction");
  data_drive_a: assert property (q.lshift == 8'h00 && !q.dir[2] |-> io_pad.out[2] == (q.data[2] ^ q.inv[2]))
    else $error("output level does not follow written data");
  rise_event_a: assert property ((q.sense[1:0] == 2'h1 && $rose(q.io_s2[0])
                                  && q.io_prev[0] == 1'b0 && !q.inv[0]) |=> q.evt[0])
    else $error("rising edge not recorded");
  masked_src_a: assert property ((ev[0] && q.mask[0] && !q.src[0]) |=> !q.src[0])
    else $error("masked line raised source flag");
  unmasked_src_a: assert property ((ev[4] && !q.mask[4]) |=> q.src[4] && !irq_out_n)
    else $error("unmasked event did not raise interrupt");
  w1c_clear_a: assert property ((wr_en && q.ptr == gxp_pkg::ADR_SRC && q.sh[0] && !ev[0])
                                |=> !q.src[0] && !q.evt[0])
    else $error("write one did not clear flags");
  irq_release_a: assert property ((q.src != 8'h00) |-> !irq_out_n)
    else $error("interrupt high with source pending");
  sense_clear_a: assert property ((chg[0] && !ev[0]) |=> !q.evt[0] && !q.src[0])
    else $error("sense change left flags pending");
  auto_clear_a: assert property ((rd_en && q.ptr == gxp_pkg::ADR_DATA && !q.misc[0] && ev == 8'h00)
                                 |=> q.src == 8'h00)
    else $error("data read did not clear source");
  keep_source_a: assert property ((rd_en && q.misc[gxp_pkg::MISC_NO_CLR] && q.src != 8'h00)
                                  |=> q.src != 8'h00)
    else $error("read cleared source with auto-clear off");
  clk_low_a: assert property (out_sel == gxp_pkg::CLKOUT_LOW
                              |=> out_sel != gxp_pkg::CLKOUT_LOW || !osc_shared_pin_out)
    else $error("clock output not low");

  irq_seen_c: cover property ($fell(irq_out_n));
  reg_write_c: cover property (wr_en && q.ptr == gxp_pkg::ADR_DIR);
  data_read_c: cover property (rd_en && q.ptr == gxp_pkg::ADR_DATA);
  shift_c: cover property (q.lshift[1:0] == gxp_pkg::LS_A2B && io_pad.oe[4]);

endmodule

`default_nettype wire

// [testbench/gxp_i2c_host.sv]
`timescale 1ns/1ns
`default_nettype none

module gxp_i2c_host (
  // system
  input  wire logic       clk,
  // serial bus wires
  input  wire logic       sda_line,
  output logic            scl,
  output logic            sda_o,
  // read results
  output logic [7:0]      rd_byte,
  output logic            rd_stb,
  output var int          nack_cnt
);
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
    rd_byte = 8'h00;
    rd_stb = 1'b0;
    nack_cnt = 0;
  end

  // half bit, above the six-clock minimum
  task automatic half();
    repeat (8) @(negedge clk);
  endtask

  // sda moves two clocks after scl falls, so no false start or stop
  task automatic bitx(input logic b, output logic s);
    repeat (2) @(negedge clk);
    sda_o = b;
    half();
    scl = 1'b1;
    half();
    s = sda_line;
    scl = 1'b0;
  endtask

  task automatic start();
    repeat (2) @(negedge clk);
    sda_o = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_o = 1'b0;
    half();
    scl = 1'b0;
  endtask

  task automatic stop();
    repeat (2) @(negedge clk);
    sda_o = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_o = 1'b1;
    half();
  endtask

  task automatic tx(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], s);
    end
    bitx(1'b1, s);
    if (s) begin
      nack_cnt++;
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
    start();
    tx({a, 1'b0});
    tx(r);
    tx(d);
    stop();
  endtask

  // single byte read ended by a nack
  task automatic rd(input logic [6:0] a, input logic [7:0] r);
    logic [7:0] b;
    logic       s;
    start();
    tx({a, 1'b0});
    tx(r);
    start();
    tx({a, 1'b1});
    for (int i = 0; i < 8; i++) begin
      bitx(1'b1, s);
      b = {b[6:0], s};
    end
    bitx(1'b1, s);
    stop();
    rd_byte = b;
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
  endtask
endmodule

`default_nettype wire

// [testbench/test_gpio_core_irq_clock_regs.sv]
`timescale 1ns/1ns
`default_nettype none

module test_gpio_core_irq_clock_regs;
  localparam logic [6:0] DA = 7'h3e;
  localparam logic [7:0] RST_TAB [10] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
                                          8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic                    clk = 1'b0;
  logic                    srst = 1'b1;
  logic [7:0]              io_in = 8'hff;
  logic                    osc_in = 1'b0;
  logic                    scl, sda_o, sda_out, sda_oe, rd_stb, irq_n, osc_out, osc_oe, eng_en, fade_log;
  logic [7:0]              rd_byte;
  int                      nack_cnt;
  gxp_pkg::gxp_io_type     io_pad;
  gxp_pkg::gxp_i2c_in_type i2c_in;
  logic [7:0]              exp_q [$];
  int                      fail_count = 0;
  int                      checks_done = 0;
  logic [31:0]             rng = 32'h4bcb0461;

  always #10 clk = ~clk;
  // open-drain data wire with pull-up
  assign i2c_in = {scl, sda_o & (~sda_oe | sda_out)};

  gxp_core #(.DEV_ADDR(DA)) dut (
    .clk(clk), .srst(srst), .i2c_in(i2c_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .io_in(io_in), .io_pad(io_pad), .irq_out_n(irq_n), .osc_shared_pin_in(osc_in),
    .osc_shared_pin_out(osc_out), .osc_shared_pin_oe(osc_oe), .engines_enable(eng_en),
    .fade_law_log(fade_log)
  );

  gxp_i2c_host host (
    .clk(clk), .sda_line(i2c_in.sda), .scl(scl), .sda_o(sda_o),
    .rd_byte(rd_byte), .rd_stb(rd_stb), .nack_cnt(nack_cnt)
  );

  function automatic logic [7:0] rnd8();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    host.wr(DA, r, d);
  endtask

  task automatic rdx(input logic [7:0] r, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(DA, r);
  endtask

  // read results against the oldest note
  always @(posedge clk) begin
    if (rd_stb) begin
      check(rd_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    logic [7:0] d, r, v;
    logic       o;
    int         n;
    wait_clk(12);
    srst = 1'b0;
    wait_clk(5);
    check(io_pad.oe, 8'h00);
    check(io_pad.out, 8'hff);
    foreach (RST_TAB[i]) rdx(8'h07 + 8'(i), RST_TAB[i]);
    rdx(8'h11, 8'h00);
    d = rnd8();
    r = rnd8();
    wr(gxp_pkg::ADR_DATA, d);
    wr(gxp_pkg::ADR_DIR, r);
    check(io_pad.oe, ~r);
    check(io_pad.out & ~r, d & ~r);
    repeat (3) begin
      io_in = rnd8();
      rdx(gxp_pkg::ADR_DATA, io_in);
    end
    v = rnd8();
    wr(gxp_pkg::ADR_INVERT, v);
    rdx(gxp_pkg::ADR_DATA, io_in ^ v);
    wr(gxp_pkg::ADR_INVERT, 8'h00);
    wr(gxp_pkg::ADR_DIR, 8'hff);
    io_in = 8'hff;
    host.wr(DA ^ 7'h01, gxp_pkg::ADR_DIR, 8'h00);
    rdx(gxp_pkg::ADR_DIR, 8'hff);
    wr(gxp_pkg::ADR_MASK, 8'hfe);
    for (int c = 0; c < 4; c++) begin
      wr(gxp_pkg::ADR_SENSE_LO, 8'(c));
      io_in[0] = 1'b0;
      wait_clk(8);
      rdx(gxp_pkg::ADR_EVT, {7'h0, c[1]});
      wr(gxp_pkg::ADR_EVT, 8'h01);
      rdx(gxp_pkg::ADR_SRC, 8'h00);
      io_in[0] = 1'b1;
      wait_clk(8);
      check(8'(irq_n), 8'(!c[0]));
      rdx(gxp_pkg::ADR_SRC, {7'h0, c[0]});
      wr(gxp_pkg::ADR_SRC, 8'h01);
      rdx(gxp_pkg::ADR_EVT, 8'h00);
      check(8'(irq_n), 8'h01);
    end
    wr(gxp_pkg::ADR_MASK, 8'hff);
    io_in[0] = 1'b0;
    wait_clk(8);
    check(8'(irq_n), 8'h01);
    rdx(gxp_pkg::ADR_EVT, 8'h01);
    rdx(gxp_pkg::ADR_SRC, 8'h00);
    wr(gxp_pkg::ADR_SENSE_LO, 8'h01);
    rdx(gxp_pkg::ADR_EVT, 8'h00);
    wr(gxp_pkg::ADR_MASK, 8'hef);
    wr(gxp_pkg::ADR_SENSE_HI, 8'h02);
    io_in[4] = 1'b0;
    wait_clk(8);
    rdx(gxp_pkg::ADR_SRC, 8'h10);
    rdx(gxp_pkg::ADR_DATA, io_in);
    check(8'(irq_n), 8'h01);
    rdx(gxp_pkg::ADR_SRC, 8'h00);
    rdx(gxp_pkg::ADR_EVT, 8'h10);
    for (int p = 0; p < 4; p++) begin
      wr(gxp_pkg::ADR_LSHIFT, 8'h01 << (2 * p));
      io_in[p] = ~io_in[p];
      wait_clk(4);
      check(8'(io_pad.out[p+4]), 8'(io_in[p]));
      wr(gxp_pkg::ADR_LSHIFT, 8'h02 << (2 * p));
      io_in[p+4] = ~io_in[p+4];
      wait_clk(4);
      check(8'(io_pad.out[p]), 8'(io_in[p+4]));
    end
    wr(gxp_pkg::ADR_LSHIFT, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(gxp_pkg::ADR_CLK, 8'h1f | 8'(s << 5));
      wait_clk(3);
      check(8'({osc_oe, eng_en, osc_out}), {5'h0, 1'b1, s == 1 || s == 2, 1'b1});
    end
    wr(gxp_pkg::ADR_CLK, 8'h00);
    wait_clk(3);
    check(8'({osc_oe, osc_out}), 8'h00);
    // internal source, output divided by two
    wr(gxp_pkg::ADR_CLK, 8'h52);
    n = 0;
    repeat (480) begin
      o = osc_out;
      @(negedge clk);
      if (osc_out && !o) begin
        n++;
      end
    end
    check(8'(n >= 9 && n <= 11), 8'h01);
    // external clock on the shared pin as input, passed straight through
    wr(gxp_pkg::ADR_CLK, 8'h21);
    osc_in = 1'b1;
    wait_clk(6);
    check(8'({osc_oe, eng_en, osc_out}), 8'h03);
    osc_in = 1'b0;
    wait_clk(6);
    check(8'(osc_out), 8'h00);
    wr(gxp_pkg::ADR_MISC, 8'h80);
    wait_clk(2);
    check(8'(fade_log), 8'h01);
    rdx(gxp_pkg::ADR_MISC, 8'h80);
    // auto-clear off: a data read leaves the source pending
    wr(gxp_pkg::ADR_MISC, 8'h01);
    io_in[4] = 1'b0;
    wait_clk(8);
    rdx(gxp_pkg::ADR_DATA, io_in);
    rdx(gxp_pkg::ADR_SRC, 8'h10);
    check(8'(irq_n), 8'h00);
    wr(gxp_pkg::ADR_EVT, 8'h10);
    rdx(gxp_pkg::ADR_SRC, 8'h00);
    check(8'(irq_n), 8'h01);
    check(8'(nack_cnt), 8'h03);
    wait_clk(4);
    check(8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule

`default_nettype wire
